// [rtl/gpp_pkg.sv]
// package for the general purpose pin port: map, fields, carriers
package gpp_pkg;
	localparam int unsigned AW = 4;
	localparam int unsigned NPIN = 8;
	// register word indices (byte address is index times 4)
	localparam logic [AW-1:0] A_DATA    = 4'h0;
	localparam logic [AW-1:0] B_DATA    = 4'h1;
	localparam logic [AW-1:0] A_DIR     = 4'h2;
	localparam logic [AW-1:0] B_DIR     = 4'h3;
	localparam logic [AW-1:0] RSVD_SLOT = 4'h4;
	localparam logic [AW-1:0] B_RDR     = 4'h5;
	localparam logic [AW-1:0] B_PE      = 4'h6;
	localparam logic [AW-1:0] B_PS      = 4'h7;
	localparam logic [AW-1:0] B_IE      = 4'h8;
	localparam logic [AW-1:0] B_IF      = 4'h9;
	localparam logic [AW-1:0] A_RDR     = 4'hA;
	localparam logic [AW-1:0] A_PE      = 4'hB;
	localparam logic [7:0]  RST8      = 8'h00;
	localparam logic [7:0]  RSVD_VAL  = 8'h00;
	localparam logic [31:0] BAD_DATA  = 32'h00000000;
	localparam logic [23:0] PAD_HI    = 24'h000000;
	// per-port pin drive bundle
	typedef struct packed {
		logic [NPIN-1:0] out;
		logic [NPIN-1:0] oe;
		logic [NPIN-1:0] reduced;
		logic [NPIN-1:0] pull_up;
		logic [NPIN-1:0] pull_dn;
	} gpp_pins_t;
	typedef enum logic [1:0] {
		BS_IDLE = 2'b01,
		BS_RESP = 2'b10
	} gpp_bus_t;
endpackage

// [rtl/gpp_port.sv]
// general purpose pin port: two 8-bit ports, direction, drive, pull and edge events
// Functional notes
// - with interrupt enabled, pull select 0 means falling edge, 1 rising edge
// - input with pull enable: select 0 pull-up, 1 pull-down; else no pull
// - output pins drive level bit; reduced drive bit 0 full, 1 reduced
// - in output mode each data bit is driven onto its pin through an output register
// - data read gives stored bit if direction 1, else buffered pin
// - port without pull-down or edge select has pull select fixed at 0
// - edge detection and interrupt enable exist only on the capable port
// - edge detection keeps working while the capable pin is an output
// - pin inputs are synchronised before they reach read data
// - direction bit 1 makes pin output, 0 input, each of 8 bits
// - data and direction registers read and write at any time
// - reserved slot reads 0x00 and ignores writes
`timescale 1ns/1ps
module gpp_port (
	// clock and reset
	input  wire logic                mclk,
	input  wire logic                arst_n,
	// avalon-mm slave
	input  wire logic [31:0]         avs_address,
	input  wire logic                avs_read,
	input  wire logic                avs_write,
	input  wire logic [31:0]         avs_writedata,
	input  wire logic [3:0]          avs_byteenable,
	output logic      [31:0]         avs_readdata,
	output logic                     avs_waitrequest,
	// pins
	input  wire logic [7:0]          pin_a_in,
	input  wire logic [7:0]          pin_b_in,
	output gpp_pkg::gpp_pins_t       pins_a,
	output gpp_pkg::gpp_pins_t       pins_b,
	// event request
	output logic                     port_b_irq
);
	// ----------------------------------------
	// reset release
	// ----------------------------------------
	logic rs1_q, rst_n_q;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rs1_q   <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rs1_q   <= 1'b1;
			rst_n_q <= rs1_q;
		end
	end

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [7:0] a_s1_q, a_s2_q, b_s1_q, b_s2_q, b_prev_q;
	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			a_s1_q   <= gpp_pkg::RST8;
			a_s2_q   <= gpp_pkg::RST8;
			b_s1_q   <= gpp_pkg::RST8;
			b_s2_q   <= gpp_pkg::RST8;
			b_prev_q <= gpp_pkg::RST8;
		end else begin
			a_s1_q   <= pin_a_in;
			a_s2_q   <= a_s1_q;
			b_s1_q   <= pin_b_in;
			b_s2_q   <= b_s1_q;
			b_prev_q <= b_s2_q;
		end
	end

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	function automatic logic hit(input logic [31:0] addr, input logic [3:0] idx);
		hit = (addr[31:6] == 26'h0) && (addr[5:2] == idx) && (addr[1:0] == 2'h0);
	endfunction

	gpp_pkg::gpp_bus_t bst_q;
	wire        acc   = (avs_read | avs_write) && (bst_q == gpp_pkg::BS_IDLE);
	wire        wr    = avs_write && (bst_q == gpp_pkg::BS_IDLE) && avs_byteenable[0];
	wire [7:0]  wd    = avs_writedata[7:0];

	logic [7:0] a_dat_q, b_dat_q, a_dir_q, b_dir_q;
	logic [7:0] a_rdr_q, b_rdr_q, a_pe_q, b_pe_q, b_ps_q, b_ie_q, b_if_q;

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			a_dat_q <= gpp_pkg::RST8;
			b_dat_q <= gpp_pkg::RST8;
			a_dir_q <= gpp_pkg::RST8;
			b_dir_q <= gpp_pkg::RST8;
			a_rdr_q <= gpp_pkg::RST8;
			b_rdr_q <= gpp_pkg::RST8;
			a_pe_q  <= gpp_pkg::RST8;
			b_pe_q  <= gpp_pkg::RST8;
			b_ps_q  <= gpp_pkg::RST8;
			b_ie_q  <= gpp_pkg::RST8;
		end else if (wr) begin
			if (hit(avs_address, gpp_pkg::A_DATA)) a_dat_q <= wd;
			if (hit(avs_address, gpp_pkg::B_DATA)) b_dat_q <= wd;
			if (hit(avs_address, gpp_pkg::A_DIR))  a_dir_q <= wd;
			if (hit(avs_address, gpp_pkg::B_DIR))  b_dir_q <= wd;
			if (hit(avs_address, gpp_pkg::A_RDR))  a_rdr_q <= wd;
			if (hit(avs_address, gpp_pkg::B_RDR))  b_rdr_q <= wd;
			if (hit(avs_address, gpp_pkg::A_PE))   a_pe_q  <= wd;
			if (hit(avs_address, gpp_pkg::B_PE))   b_pe_q  <= wd;
			if (hit(avs_address, gpp_pkg::B_PS))   b_ps_q  <= wd;
			if (hit(avs_address, gpp_pkg::B_IE))   b_ie_q  <= wd;
		end
	end

	// ----------------------------------------
	// edge detection, port b only
	// ----------------------------------------
	// direction is not looked at, so output pins still see their own edges
	wire [7:0] rise    = b_s2_q & ~b_prev_q;
	wire [7:0] fall    = ~b_s2_q & b_prev_q;
	wire [7:0] edge_ok = b_ie_q & ((b_ps_q & rise) | (~b_ps_q & fall));
	wire       clr_if  = wr && hit(avs_address, gpp_pkg::B_IF);
	wire [7:0] clr_msk = clr_if ? wd : gpp_pkg::RST8;

	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			b_if_q     <= gpp_pkg::RST8;
			port_b_irq <= 1'b0;
		end else begin
			b_if_q     <= (b_if_q & ~clr_msk) | edge_ok;
			port_b_irq <= |((b_if_q & ~clr_msk) | edge_ok);
		end
	end

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	wire [7:0] a_rd = (a_dir_q & a_dat_q) | (~a_dir_q & a_s2_q);
	wire [7:0] b_rd = (b_dir_q & b_dat_q) | (~b_dir_q & b_s2_q);
	logic [7:0] rsel;
	always_comb begin
		rsel = gpp_pkg::RST8;
		if (hit(avs_address, gpp_pkg::A_DATA))    rsel = a_rd;
		if (hit(avs_address, gpp_pkg::B_DATA))    rsel = b_rd;
		if (hit(avs_address, gpp_pkg::A_DIR))     rsel = a_dir_q;
		if (hit(avs_address, gpp_pkg::B_DIR))     rsel = b_dir_q;
		if (hit(avs_address, gpp_pkg::RSVD_SLOT)) rsel = gpp_pkg::RSVD_VAL;
		if (hit(avs_address, gpp_pkg::A_RDR))     rsel = a_rdr_q;
		if (hit(avs_address, gpp_pkg::B_RDR))     rsel = b_rdr_q;
		if (hit(avs_address, gpp_pkg::A_PE))      rsel = a_pe_q;
		if (hit(avs_address, gpp_pkg::B_PE))      rsel = b_pe_q;
		if (hit(avs_address, gpp_pkg::B_PS))      rsel = b_ps_q;
		if (hit(avs_address, gpp_pkg::B_IE))      rsel = b_ie_q;
		if (hit(avs_address, gpp_pkg::B_IF))      rsel = b_if_q;
	end

	// ----------------------------------------
	// bus handshake: one wait cycle per access
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			bst_q           <= gpp_pkg::BS_IDLE;
			avs_waitrequest <= 1'b1;
			avs_readdata    <= gpp_pkg::BAD_DATA;
		end else begin
			case (bst_q)
				gpp_pkg::BS_IDLE: begin
					if (acc) begin
						bst_q           <= gpp_pkg::BS_RESP;
						avs_waitrequest <= 1'b0;
						avs_readdata    <= {gpp_pkg::PAD_HI, rsel};
					end
				end
				gpp_pkg::BS_RESP: begin
					bst_q           <= gpp_pkg::BS_IDLE;
					avs_waitrequest <= 1'b1;
				end
				default: begin
					bst_q           <= gpp_pkg::BS_IDLE;
					avs_waitrequest <= 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------
	// pin drive
	// ----------------------------------------
	gpp_pkg::gpp_pins_t a_d, b_d;
	assign a_d.out     = a_dat_q;
	assign a_d.oe      = a_dir_q;
	assign a_d.reduced = a_dir_q & a_rdr_q;
	assign a_d.pull_up = ~a_dir_q & a_pe_q;
	assign a_d.pull_dn = gpp_pkg::RST8;
	assign b_d.out     = b_dat_q;
	assign b_d.oe      = b_dir_q;
	assign b_d.reduced = b_dir_q & b_rdr_q;
	assign b_d.pull_up = ~b_dir_q & b_pe_q & ~b_ps_q;
	assign b_d.pull_dn = ~b_dir_q & b_pe_q & b_ps_q;

	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pins_a <= '0;
			pins_b <= '0;
		end else begin
			pins_a <= a_d;
			pins_b <= b_d;
		end
	end
endmodule

// [sim/gpp_port_properties.sv]
// checker for bus answer timing, pad drive and event request
`timescale 1ns/1ps
module gpp_port_chk (
	// clock and reset
	input wire logic               mclk,
	input wire logic               arst_n,
	// bus
	input wire logic [31:0]        avs_address,
	input wire logic               avs_read,
	input wire logic               avs_write,
	input wire logic [31:0]        avs_readdata,
	input wire logic               avs_waitrequest,
	// pads and request
	input wire gpp_pkg::gpp_pins_t pins_a,
	input wire gpp_pkg::gpp_pins_t pins_b,
	input wire logic               port_b_irq
);
	// ----
	// properties
	// ----
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("answer longer than one cycle");
	upper_zero_a: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
		else $error("upper read bits set");
	rsvd_zero_a: assert property (avs_read && avs_waitrequest && avs_address == 32'h10
		|=> !avs_waitrequest && avs_readdata == 32'h0) else $error("reserved slot not zero");
	a_no_pulldn_a: assert property (pins_a.pull_dn == 8'h00)
		else $error("port a pull-down on");
	pull_out_a: assert property (((pins_a.oe & pins_a.pull_up) |
		(pins_b.oe & (pins_b.pull_up | pins_b.pull_dn))) == 8'h00) else $error("pull on output");
	one_pull_a: assert property ((pins_b.pull_up & pins_b.pull_dn) == 8'h00)
		else $error("both pulls on");
	reduced_out_a: assert property (((pins_a.reduced & ~pins_a.oe) |
		(pins_b.reduced & ~pins_b.oe)) == 8'h00) else $error("reduced drive on input");
	irq_hold_a: assert property (port_b_irq && !avs_write && !$past(avs_write)
		|=> port_b_irq) else $error("request dropped without clear");
	cover property ($rose(port_b_irq));
	cover property (avs_write && !avs_waitrequest);
	cover property (avs_read && !avs_waitrequest && avs_address == 32'h24);
endmodule
bind gpp_port gpp_port_chk u_chk (.mclk, .arst_n, .avs_address, .avs_read, .avs_write,
	.avs_readdata, .avs_waitrequest, .pins_a, .pins_b, .port_b_irq);

// [sim/gpp_pad.sv]
// board model: pad level from port drive, pulls and a weak outside source
`timescale 1ns/1ps
module gpp_pad (
	// drive from the port
	input  wire gpp_pkg::gpp_pins_t pins,
	// weak outside source, loses to pulls
	input  wire logic [7:0]         ext,
	// level back to the port
	output logic      [7:0]         lvl
);
	assign lvl = pins.oe & pins.out | ~pins.oe & (pins.pull_up | ~pins.pull_dn & ext);
endmodule

// [sim/gpp_port_test.sv]
// self-checking bench: register model, pads and pin edge events
`timescale 1ns/1ps
module gpp_port_test;
	// ----
	// signals and instances
	// ----
	logic              mclk = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic              wrq, irq;
	logic [31:0]       avs_address = 32'h0, avs_writedata = 32'h0, rdata, q;
	logic [3:0]        avs_byteenable = 4'hF, a, b;
	logic [7:0]        ia, ib, o, v, pend = 8'h00;
	logic [7:0]        ext [2] = '{8'h5A, 8'hC3};
	logic [7:0]        r [16] = '{default: 8'h00};
	logic [31:0]       seed = 32'hEA514864;
	gpp_pkg::gpp_pins_t pa, pb;
	int                cyc = 0, i, bad_count = 0, total_checks = 0;
	gpp_port DUT (.mclk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata(rdata), .avs_waitrequest(wrq), .pin_a_in(ia),
		.pin_b_in(ib), .pins_a(pa), .pins_b(pb), .port_b_irq(irq));
	gpp_pad pad_a (.pins(pa), .ext(ext[0]), .lvl(ia));
	gpp_pad pad_b (.pins(pb), .ext(ext[1]), .lvl(ib));
	initial forever #2 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 8000) begin
			bad_count++;
			test_done();
		end
	end
	function automatic logic [7:0] rb();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction
	// pad level: driven bit, else pull (port a pulls up only), else outside source
	function automatic logic [7:0] lvl(int p);
		logic [7:0] d, e;
		d = r[2+p];
		e = p ? r[6] : r[11];
		return d & r[p] | ~d & (e & ~(p ? r[7] : 8'h00) | ~e & ext[p]);
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic w, input logic [3:0] ad, input logic [7:0] d, input logic [3:0] e);
		@(posedge mclk);
		avs_address <= {26'h0, ad, 2'b00};
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h0, d};
		avs_byteenable <= e;
		do @(posedge mclk); while (wrq !== 1'b0);
		q = rdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] ad);
		acc(1'b0, ad, 8'h00, 4'hF);
		chk(q, {24'h0, ad < 2 ? lvl(ad) : ad == 9 ? pend : r[ad]});
	endtask
	// edge seen on port b since level n0, polarity by pull select
	task automatic upd(input logic [7:0] n0);
		logic [7:0] n;
		repeat (6) @(posedge mclk);
		n = lvl(1);
		pend = pend | r[8] & (r[7] & ~n0 & n | ~r[7] & n0 & ~n);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ----
	// sequence
	// ----
	initial begin
		repeat (3) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		for (i = 0; i < 16; i++) rd(i[3:0]);
		repeat (60) begin
			o = lvl(1);
			@(posedge mclk);
			ext[0] <= rb();
			ext[1] <= rb();
			upd(o);
			v = rb();
			a = v[3:0];
			b = v[6] ? 4'hF : 4'hE;
			v = rb();
			o = lvl(1);
			acc(1'b1, a, v, b);
			if (b[0] && a != 4 && a < 12)
				if (a == 9) pend = pend & ~v;
				else r[a] = v;
			upd(o);
			chk({16'h0, pa.reduced, pb.reduced}, {16'h0, r[2] & r[10], r[3] & r[5]});
			chk({16'h0, pa.oe, pb.oe}, {16'h0, r[2], r[3]});
			rd(4'h0);
			rd(4'h1);
			rd(4'h9);
			v = rb();
			rd(v[7:4]);
			chk({31'h0, irq}, {31'h0, |pend});
		end
		test_done();
	end
endmodule
